/* File: verilog/vfr_regs.svh */
// constants for the output voltage fault response controller
`ifndef VFR_REGS_SVH
`define VFR_REGS_SVH

// command codes of the two response configuration bytes
`define VFR_CMD_OV_RESP 8'h41
`define VFR_CMD_UV_RESP 8'h45

// reset values of the response configuration bytes
`define VFR_OV_RESP_RST 8'h80
`define VFR_UV_RESP_RST 8'h7f

// field positions inside a response byte
`define VFR_ACT_MSB 7
`define VFR_ACT_LSB 6
`define VFR_RETRY_MSB 5
`define VFR_RETRY_LSB 3
`define VFR_DEG_MSB 2
`define VFR_DEG_LSB 0

// supervisor sample period and its length in system clock cycles
`define VFR_SAMPLE_PERIOD_NS 12200
`define VFR_CLK_PERIOD_NS 10
`define VFR_SAMPLE_CYC ((`VFR_SAMPLE_PERIOD_NS) / (`VFR_CLK_PERIOD_NS))

`endif

/* File: verilog/vfr_pkg.sv */
// types shared by the output voltage fault response controller
package vfr_pkg;

  // response action field values
  typedef enum logic [1:0] {
    ACT_IGNORE = 2'b00,
    ACT_DELAYED = 2'b01,
    ACT_SHUT_A = 2'b10,
    ACT_SHUT_B = 2'b11
  } vfr_action_e;

  // channel run state
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_ON = 3'b001,
    ST_SEQ_OFF = 3'b010,
    ST_RETRY_WAIT = 3'b011,
    ST_LATCHED = 3'b100
  } vfr_state_e;

  // one command from the bus host
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [7:0] wdata;
  } vfr_cmd_s;

  // status bits raised by voltage faults
  typedef struct packed {
    logic byte_vout;
    logic word_vout;
    logic vout_ov;
    logic vout_uv;
  } vfr_status_s;

endpackage

/* File: verilog/vfr_ctrl.sv */
// output voltage fault response controller for one supply channel
// Functional notes
// R1: only fast supervisor voltage faults are handled here
// R2: fault sets summary, word and vout status bits
// R3: fault drives host alert low, any action
// R4: action 00 keeps channel running
// R5: action 01 waits delay, shuts if persisting
// R6: action 1x shuts now or sequences off
// R7: after shutdown follow retry field; after sequencing off the undervoltage retry field decides
// R8: retry 000 latches off until cleared
// R9: other retry values restart up to global count
// R10: new retry value applies after off-on
// R11: deglitch 000 adds no detection delay
// R12: deglitch n ignores fault for n samples
// R13: latch cleared by control, operation or bias
// R14: clear faults resets status and alert only
// R15: restarts spaced by global retry delay
// R16: deglitch count restarts when fault vanishes
`timescale 1ns/1ps
`default_nettype none
`include "vfr_regs.svh"

module vfr_ctrl (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire vfr_pkg::vfr_cmd_s i_cmd,
  input wire logic i_ov_cmp,
  input wire logic i_uv_cmp,
  input wire logic i_control_pin,
  input wire logic i_op_on,
  input wire logic i_bias_ok,
  input wire logic i_clear_faults,
  input wire logic i_track_en,
  input wire logic [15:0] i_toff_delay,
  input wire logic [15:0] i_retry_delay,
  input wire logic [2:0] i_retry_count,
  output logic [7:0] o_cmd_rdata,
  output logic o_cmd_ack,
  output logic o_chan_en,
  output logic o_host_alert_n,
  output vfr_pkg::vfr_status_s o_status
);

  localparam logic [10:0] SAMPLE_LAST = 11'(`VFR_SAMPLE_CYC - 1);
  // response configuration bytes
  logic [7:0] out_overvolt_response_cfg;
  logic [7:0] out_undervolt_response_cfg;
  logic [7:0] resp_cfg [2]; // index 0 overvoltage, 1 undervoltage
  assign resp_cfg[0] = out_overvolt_response_cfg;
  assign resp_cfg[1] = out_undervolt_response_cfg;

  // synchronisers for pins
  logic [1:0] cmp_m; // first stage, comparators
  logic [1:0] cmp_s; // settled comparator levels
  logic ctrl_m;
  logic ctrl_s;
  logic bias_m;
  logic bias_s;

  // sample tick generator
  logic [10:0] tick_cnt;
  logic tick;

  // per fault type detection and action timing
  logic [2:0] deg_cnt [2]; // samples the fault has persisted
  logic [1:0] det; // deglitched fault present
  logic [1:0] det_q; // det one cycle ago
  logic [1:0] det_rise; // newly detected fault
  logic [1:0] pend; // delayed action running
  logic [2:0] act_cnt [2]; // samples waited under delayed action
  logic [1:0] shut_req; // shutdown asked by fault type

  // channel control
  vfr_pkg::vfr_state_e state;
  vfr_pkg::vfr_state_e next_state;
  logic [15:0] tmr; // turn-off and retry delay timer, in samples
  logic [2:0] retry_left; // restarts still allowed
  logic [2:0] retry_act [2]; // retry fields in force for this on period
  logic cmd_on; // channel commanded on
  logic shut_any;
  logic [2:0] shut_retry; // overvoltage retry field if it asks shutdown this cycle, else the undervoltage one
  logic off_done; // turn-off sequence finished this cycle
  logic go_retry; // finished shutdown leads to a restart wait

  // two flip-flop synchronisers for all asynchronous pins
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      {cmp_m, cmp_s, ctrl_m, ctrl_s, bias_m, bias_s} <= 8'h00;
    else
    begin
      cmp_m <= {i_uv_cmp, i_ov_cmp};
      cmp_s <= cmp_m;
      ctrl_m <= i_control_pin;
      ctrl_s <= ctrl_m;
      bias_m <= i_bias_ok;
      bias_s <= bias_m;
    end
  end

  // supervisor sample tick, one pulse per sample period
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      tick_cnt <= 11'h0;
    else if (tick)
      tick_cnt <= 11'h0;
    else
      tick_cnt <= tick_cnt + 11'h1;
  end
  assign tick = (tick_cnt == SAMPLE_LAST);

  // configuration byte writes and registered read-back
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      out_overvolt_response_cfg <= `VFR_OV_RESP_RST;
      out_undervolt_response_cfg <= `VFR_UV_RESP_RST;
      {o_cmd_rdata, o_cmd_ack} <= 9'h000;
    end
    else
    begin
      o_cmd_ack <= i_cmd.valid;
      // writes store the byte, reads return it; other codes read zero
      if (i_cmd.valid && i_cmd.write && i_cmd.code == `VFR_CMD_OV_RESP)
        out_overvolt_response_cfg <= i_cmd.wdata;
      else if (i_cmd.valid && i_cmd.write && i_cmd.code == `VFR_CMD_UV_RESP)
        out_undervolt_response_cfg <= i_cmd.wdata;
      if (i_cmd.valid && !i_cmd.write && i_cmd.code == `VFR_CMD_OV_RESP)
        o_cmd_rdata <= out_overvolt_response_cfg;
      else if (i_cmd.valid && !i_cmd.write && i_cmd.code == `VFR_CMD_UV_RESP)
        o_cmd_rdata <= out_undervolt_response_cfg;
      else if (i_cmd.valid && !i_cmd.write)
        o_cmd_rdata <= 8'h00;
    end
  end

  // deglitch and action timing, one copy per fault type
  for (genvar g = 0; g < 2; g++)
  begin : g_fault
    logic [1:0] act;
    logic [2:0] deg;
    assign act = resp_cfg[g][`VFR_ACT_MSB:`VFR_ACT_LSB];
    assign deg = resp_cfg[g][`VFR_DEG_MSB:`VFR_DEG_LSB];

    // count samples while the comparator holds, restart when it drops
    always_ff @(posedge i_clk_sys)
    begin
      if (!i_rst_n)
        {deg_cnt[g], det[g]} <= 4'h0;
      else
      begin
        if (!cmp_s[g])
          deg_cnt[g] <= 3'h0; // [R16]
        else if (tick && deg_cnt[g] < deg)
          deg_cnt[g] <= deg_cnt[g] + 3'h1; // [R12]
        // zero deglitch passes the fault at once [R11] [R1]
        det[g] <= cmp_s[g] && (deg_cnt[g] >= deg);
      end
    end

    // delayed action: wait the sample count, then check the fault again
    always_ff @(posedge i_clk_sys)
    begin
      // reset, and any state but on, drops a pending delayed action
      if (!i_rst_n || state != vfr_pkg::ST_ON)
        {pend[g], act_cnt[g]} <= 4'h0;
      else if (det_rise[g] && act == vfr_pkg::ACT_DELAYED)
      begin
        pend[g] <= 1'b1; // [R5]
        act_cnt[g] <= 3'h0;
      end
      else if (pend[g] && act_cnt[g] == deg)
        pend[g] <= 1'b0;
      else if (pend[g] && tick)
        act_cnt[g] <= act_cnt[g] + 3'h1;
    end

    // action 00 never asks; 01 asks only if still faulted; 1x at once
    assign shut_req[g] = (act != vfr_pkg::ACT_IGNORE) &&
      ((det_rise[g] && act[1]) ||
       (pend[g] && act_cnt[g] == deg && det[g])); // [R4] [R5] [R6]
  end
  assign det_rise = det & ~det_q;
  assign shut_any = (state == vfr_pkg::ST_ON) && (shut_req != 2'h0);
  assign shut_retry = shut_req[0] ? retry_act[0] : retry_act[1];
  assign cmd_on = ctrl_s && i_op_on;

  // edge history of detected faults
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      det_q <= 2'h0;
    else
      det_q <= det;
  end

  // status bits and alert: a new fault wins over clear faults
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      o_status <= '0;
      o_host_alert_n <= 1'b1;
    end
    else
    begin
      if (det_rise != 2'h0)
      begin
        o_status.byte_vout <= 1'b1; // [R2]
        o_status.word_vout <= 1'b1; // [R2]
        o_status.vout_ov <= o_status.vout_ov | det_rise[0]; // [R2]
        o_status.vout_uv <= o_status.vout_uv | det_rise[1]; // [R2]
        o_host_alert_n <= 1'b0; // [R3]
      end
      else if (i_clear_faults)
      begin
        o_status <= '0; // [R14]
        o_host_alert_n <= 1'b1; // [R14]
      end
    end
  end

  // finished shutdown: restart if retry enabled and budget left
  assign go_retry = (shut_retry != 3'h0) && (retry_left != 3'h0); // [R8] [R9]
  assign off_done = (state == vfr_pkg::ST_SEQ_OFF) && tick && (tmr >= i_toff_delay);

  // channel state transitions
  always_comb
  begin
    next_state = state;
    case (state)
      vfr_pkg::ST_OFF:
        if (cmd_on)
          next_state = vfr_pkg::ST_ON;
      vfr_pkg::ST_ON:
        if (shut_any && i_track_en)
          next_state = vfr_pkg::ST_SEQ_OFF; // [R6]
        else if (shut_any && go_retry)
          next_state = vfr_pkg::ST_RETRY_WAIT; // [R7]
        else if (shut_any)
          next_state = vfr_pkg::ST_LATCHED; // [R8]
      vfr_pkg::ST_SEQ_OFF:
        if (off_done && go_retry)
          next_state = vfr_pkg::ST_RETRY_WAIT; // [R7]
        else if (off_done)
          next_state = vfr_pkg::ST_LATCHED;
      vfr_pkg::ST_RETRY_WAIT:
        if (tick && tmr >= i_retry_delay)
          next_state = vfr_pkg::ST_ON; // [R15]
      vfr_pkg::ST_LATCHED:
        next_state = vfr_pkg::ST_LATCHED; // clear faults cannot free it [R14]
      default:
        next_state = vfr_pkg::ST_OFF;
    endcase
    // command off or bias loss ends retries and clears the latch
    if (!cmd_on || !bias_s)
      next_state = vfr_pkg::ST_OFF; // [R9] [R13]
  end

  // channel state, enable output and timers
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      state <= vfr_pkg::ST_OFF;
      {o_chan_en, tmr} <= 17'h00000;
    end
    else
    begin
      state <= next_state;
      // channel still runs while sequencing off
      o_chan_en <= (next_state == vfr_pkg::ST_ON) || (next_state == vfr_pkg::ST_SEQ_OFF);
      if (next_state != state)
        tmr <= 16'h0;
      else if (tick && tmr != 16'hffff)
        tmr <= tmr + 16'h1;
    end
  end

  // retry budget and retry fields in force, taken at each off-then-on
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      {retry_left, retry_act[0], retry_act[1]} <= 9'h000;
    else if (state == vfr_pkg::ST_OFF && next_state == vfr_pkg::ST_ON)
    begin
      retry_left <= i_retry_count; // [R9]
      retry_act[0] <= out_overvolt_response_cfg[`VFR_RETRY_MSB:`VFR_RETRY_LSB]; // [R10]
      retry_act[1] <= out_undervolt_response_cfg[`VFR_RETRY_MSB:`VFR_RETRY_LSB]; // [R10]
    end
    else if (next_state == vfr_pkg::ST_RETRY_WAIT && state != vfr_pkg::ST_RETRY_WAIT)
      retry_left <= retry_left - 3'h1; // [R9]
  end

  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  sequence s_new_fault;
    det_rise != 2'h0;
  endsequence

  chk_alert_on_fault: assert property (s_new_fault |=> !o_host_alert_n) // [R3]
    else $error("alert not low after fault");
  chk_status_ov_set: assert property (det_rise[0] |=> o_status.vout_ov && o_status.byte_vout) // [R2]
    else $error("status not set after ov fault");
  chk_ignore_action: assert property
    (resp_cfg[1][`VFR_ACT_MSB:`VFR_ACT_LSB] == 2'b00 |-> !shut_req[1]) // [R4]
    else $error("ignore action asked shutdown");
  chk_delayed_persist: assert property
    (shut_req[0] && resp_cfg[0][`VFR_ACT_MSB:`VFR_ACT_LSB] == 2'b01 |-> det[0]) // [R5]
    else $error("delayed shutdown without fault");
  chk_immediate_off: assert property
    (shut_any && !i_track_en && cmd_on && bias_s |=> !o_chan_en) // [R6]
    else $error("channel not off after fault");
  chk_latch_holds: assert property
    (state == vfr_pkg::ST_LATCHED && cmd_on && bias_s |=> state == vfr_pkg::ST_LATCHED) // [R8]
    else $error("latched channel left latch");
  chk_retry_budget: assert property
    ($rose(state == vfr_pkg::ST_RETRY_WAIT) |-> $past(retry_left) != 3'h0) // [R9]
    else $error("retry without budget");
  chk_deglitch_min: assert property ($rose(det[0]) |-> $past(deg_cnt[0]) >= $past(resp_cfg[0][2:0])) // [R12]
    else $error("fault passed before deglitch");
  chk_deglitch_clear: assert property (!cmp_s[0] |=> deg_cnt[0] == 3'h0 && !det[0]) // [R16]
    else $error("deglitch not restarted");
  chk_clear_faults: assert property
    (i_clear_faults && det_rise == 2'h0 |=> o_host_alert_n && !o_status.byte_vout) // [R14]
    else $error("clear faults not applied");
  chk_retry_wait_off: assert property
    (state == vfr_pkg::ST_RETRY_WAIT && !tick && cmd_on && bias_s |=> !o_chan_en) // [R15]
    else $error("restart before retry delay");

endmodule
`default_nettype wire

/* File: tb/vfr_supply_model.sv */
// behavioural supply channel that feeds the fast supervisor comparators
`timescale 1ns/1ps
`default_nettype none

module vfr_supply_model (
  input wire logic i_chan_en,
  input wire logic i_inj_ov,
  input wire logic i_inj_uv,
  output logic o_ov_cmp,
  output logic o_uv_cmp
);
  // a stopped rail can show neither fault, so injected faults need a running channel
  assign o_ov_cmp = i_chan_en & i_inj_ov;
  assign o_uv_cmp = i_chan_en & i_inj_uv;
endmodule

`default_nettype wire

/* File: tb/vfr_ctrl_tb.sv */
// self-checking testbench of the output voltage fault response controller
`timescale 1ns/1ps
`default_nettype none

module vfr_ctrl_tb;
  logic i_clk_sys, i_rst_n, i_control_pin, i_op_on, i_clear_faults;
  logic inj_ov, inj_uv, ov_cmp, uv_cmp;
  logic i_track_en, i_bias_ok;
  vfr_pkg::vfr_cmd_s i_cmd;
  logic [7:0] o_cmd_rdata;
  logic o_cmd_ack, o_chan_en, o_host_alert_n;
  vfr_pkg::vfr_status_s o_status;
  int n_errors = 0;
  int n_compared = 0;

  // design under test; delays and retry count are held constant
  vfr_ctrl uut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_cmd(i_cmd), .i_ov_cmp(ov_cmp),
    .i_uv_cmp(uv_cmp), .i_control_pin(i_control_pin), .i_op_on(i_op_on), .i_bias_ok(i_bias_ok),
    .i_clear_faults(i_clear_faults), .i_track_en(i_track_en), .i_toff_delay(16'h0001),
    .i_retry_delay(16'h0001), .i_retry_count(3'h1), .o_cmd_rdata(o_cmd_rdata),
    .o_cmd_ack(o_cmd_ack), .o_chan_en(o_chan_en), .o_host_alert_n(o_host_alert_n),
    .o_status(o_status));

  // far-side supply channel
  vfr_supply_model sup (.i_chan_en(o_chan_en), .i_inj_ov(inj_ov), .i_inj_uv(inj_uv),
    .o_ov_cmp(ov_cmp), .o_uv_cmp(uv_cmp));

  // 100 mhz clock
  initial
  begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  // compare one value and count it
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // verdict and end of run
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // one host command; ack and read data are looked at in the answer cycle
  task automatic cmd(input logic w, input logic [7:0] code, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_cmd <= '{valid: 1'b1, write: w, code: code, wdata: d};
    @(posedge i_clk_sys);
    i_cmd <= '0;
    #1;
    chk(8'(o_cmd_ack), 8'h01);
  endtask

  // read and compare a configuration byte
  task automatic rd(input logic [7:0] code, input logic [7:0] exp);
    cmd(1'b0, code, 8'h00);
    chk(o_cmd_rdata, exp);
  endtask

  // bounded wait: sel 1 watches the enable, sel 0 the alert
  task automatic wait_sig(input bit sel, input logic v, input int lim);
    int i;
    for (i = 0; i < lim; i++)
    begin
      @(posedge i_clk_sys);
      #1;
      if ((sel ? o_chan_en : o_host_alert_n) === v)
        break;
    end
    chk(8'(sel ? o_chan_en : o_host_alert_n), 8'(v));
  endtask

  // one-cycle clear-faults pulse
  task automatic clear();
    @(posedge i_clk_sys);
    i_clear_faults <= 1'b1;
    @(posedge i_clk_sys);
    i_clear_faults <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
  endtask

  // operation off then on, channel must follow
  task automatic cycle_on();
    @(posedge i_clk_sys);
    i_op_on <= 1'b0;
    wait_sig(1'b1, 1'b0, 20);
    i_op_on <= 1'b1;
    wait_sig(1'b1, 1'b1, 20);
  endtask

  // reset values, write back, unmapped code
  task automatic t_regs();
    rd(8'h41, 8'h80);
    rd(8'h45, 8'h7f);
    rd(8'h10, 8'h00);
    cmd(1'b1, 8'h10, 8'h5a);
    cmd(1'b1, 8'h45, 8'h3c);
    rd(8'h45, 8'h3c);
    rd(8'h41, 8'h80);
    $display("t_regs done");
  endtask

  // overvoltage with immediate shutdown and no retry
  task automatic t_ov_shut();
    cycle_on();
    inj_ov <= 1'b1;
    wait_sig(1'b0, 1'b0, 8);
    chk(8'(o_chan_en), 8'h00);
    chk(8'(o_status), 8'h0e);
    inj_ov <= 1'b0;
    repeat (3000) @(posedge i_clk_sys);
    chk(8'(o_chan_en), 8'h00);
    clear();
    chk(8'(o_host_alert_n), 8'h01);
    chk(8'(o_status), 8'h00);
    chk(8'(o_chan_en), 8'h00);
    cycle_on();
    $display("t_ov_shut done");
  endtask

  // undervoltage with action ignore keeps running
  task automatic t_uv_ignore();
    cmd(1'b1, 8'h45, 8'h00);
    inj_uv <= 1'b1;
    wait_sig(1'b0, 1'b0, 8);
    chk(8'(o_status), 8'h0d);
    chk(8'(o_chan_en), 8'h01);
    inj_uv <= 1'b0;
    clear();
    $display("t_uv_ignore done");
  endtask

  // deglitch of two samples: short glitches ignored, a steady fault seen
  task automatic t_deglitch();
    cmd(1'b1, 8'h41, 8'h02);
    repeat (4)
    begin
      inj_ov <= 1'b1;
      repeat (700) @(posedge i_clk_sys);
      inj_ov <= 1'b0;
      repeat (700) @(posedge i_clk_sys);
    end
    chk(8'(o_host_alert_n), 8'h01);
    inj_ov <= 1'b1;
    repeat (1200) @(posedge i_clk_sys);
    chk(8'(o_host_alert_n), 8'h01);
    wait_sig(1'b0, 1'b0, 1300);
    chk(8'(o_chan_en), 8'h01);
    inj_ov <= 1'b0;
    clear();
    $display("t_deglitch done");
  endtask

  // delayed action: a short fault is ridden out, a lasting one shuts down
  task automatic t_delayed();
    cmd(1'b1, 8'h41, 8'h41);
    cycle_on();
    cmd(1'b1, 8'h41, 8'h49);
    inj_ov <= 1'b1;
    wait_sig(1'b0, 1'b0, 1300);
    chk(8'(o_chan_en), 8'h01);
    inj_ov <= 1'b0;
    repeat (1300) @(posedge i_clk_sys);
    chk(8'(o_chan_en), 8'h01);
    clear();
    inj_ov <= 1'b1;
    wait_sig(1'b0, 1'b0, 1300);
    chk(8'(o_chan_en), 8'h01);
    wait_sig(1'b1, 1'b0, 1300);
    inj_ov <= 1'b0;
    repeat (3000) @(posedge i_clk_sys);
    chk(8'(o_chan_en), 8'h00);
    clear();
    i_bias_ok <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    i_bias_ok <= 1'b1;
    wait_sig(1'b1, 1'b1, 20);
    $display("t_delayed done");
  endtask

  // tracking on: a fault sequences the channel off after the turn-off delay
  task automatic t_track();
    cmd(1'b1, 8'h41, 8'h80);
    i_track_en <= 1'b1;
    cycle_on();
    inj_ov <= 1'b1;
    wait_sig(1'b0, 1'b0, 8);
    chk(8'(o_chan_en), 8'h01);
    wait_sig(1'b1, 1'b0, 2500);
    inj_ov <= 1'b0;
    i_track_en <= 1'b0;
    clear();
    $display("t_track done");
  endtask

  // one restart allowed, the second fault latches off
  task automatic t_retry();
    cmd(1'b1, 8'h41, 8'h88);
    cycle_on();
    inj_ov <= 1'b1;
    wait_sig(1'b0, 1'b0, 8);
    chk(8'(o_chan_en), 8'h00);
    inj_ov <= 1'b0;
    repeat (1200) @(posedge i_clk_sys);
    chk(8'(o_chan_en), 8'h00);
    wait_sig(1'b1, 1'b1, 3000);
    clear();
    inj_ov <= 1'b1;
    wait_sig(1'b1, 1'b0, 8);
    inj_ov <= 1'b0;
    repeat (3000) @(posedge i_clk_sys);
    chk(8'(o_chan_en), 8'h00);
    $display("t_retry done");
  endtask

  // hang guard
  initial
  begin
    #500us;
    n_errors++;
    final_report();
  end

  // main sequence
  initial
  begin
    i_rst_n = 1'b0;
    i_cmd = '0;
    i_control_pin = 1'b1;
    i_op_on = 1'b0;
    i_clear_faults = 1'b0;
    i_track_en = 1'b0;
    i_bias_ok = 1'b1;
    inj_ov = 1'b0;
    inj_uv = 1'b0;
    repeat (6) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    t_regs();
    t_ov_shut();
    t_uv_ignore();
    t_deglitch();
    t_delayed();
    t_track();
    t_retry();
    final_report();
  end
endmodule

`default_nettype wire
